/* File: logic/tef_framer.sv */
// T1 extended superframe framer: sync, remote alarm, CRC6, APB registers
//
// Our own choices: the APB interface to the registers and the register addresses.

// Summary of operation
// R1 - 24-frame multiframe, alignment bits 001011 in frames 4..24
// R2 - Data link bits in odd frame F bits
// R3 - CRC6 bits e1-e6 in frames 2,6..22
// R4 - Sync on definite candidate or forced lock
// R5 - Loss by 2of4, 2of5, 2 per multiframe, 4 bad
// R6 - Mode 00 sync: force or ext loss restarts search
// R7 - Mode 00 async: force locks candidate, clears memory
// R8 - Mode 01: three correct multiframes before sync
// R9 - Mode 10 sync: force steps to next candidate (code drops lock and resumes the hunt at the current alignment, no slip)
// R10 - Mode 10: no alignment, full reset, toggle flag
// R11 - Mode 11: sync needs pattern and clean CRC6
// R12 - Detect ones/zeros alarm pattern, tolerate errors
// R13 - Transmit alarm in data link, Japan variant form
// R14 - Alarm method 1 sets bit 2 of slots
// R15 - Check only if enabled, else send ones
// R16 - Count CRC6 errors while synchronous, flag them
// R17 - Auto inversion after received CRC error
// R18 - Effective inversion is OR of both causes
// R19 - Japan variant includes F bits in CRC6
// R20 - Frame loss flag while not synchronous
// R21 - Restart flag toggles when search found nothing
// R22 - Polynomial x^6+x+1, bits sent next multiframe
module tef_framer
	import tef_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxLineBit,
	input wire logic rxLineStrobe,
	input wire logic txPayloadBit,
	input wire logic txPayloadStrobe,
	output logic txLineBit,
	output logic txLineStrobe,
	output logic inSync,
	output logic remoteAlarm
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [3:0] pinMeta_ff;
	logic [3:0] pinSync_ff;
	logic rxStbDly_ff;
	logic txStbDly_ff;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta_ff <= 4'h0;
			pinSync_ff <= 4'h0;
			rxStbDly_ff <= 1'b0;
			txStbDly_ff <= 1'b0;
		end else begin
			pinMeta_ff <= {txPayloadStrobe, txPayloadBit, rxLineStrobe, rxLineBit};
			pinSync_ff <= pinMeta_ff;
			rxStbDly_ff <= pinSync_ff[1];
			txStbDly_ff <= pinSync_ff[3];
		end
	end

	logic rxFire;
	logic txFire;
	logic rxBit;
	assign rxFire = pinSync_ff[1] & ~rxStbDly_ff;
	assign txFire = pinSync_ff[3] & ~txStbDly_ff;
	assign rxBit = pinSync_ff[0];

	// ****************************************************************
	// Control register and APB slave
	// ****************************************************************
	logic [11:0] ctrl_ff;
	logic forcePulse_ff;
	logic extLossPulse_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic apbDone;
	logic ctrlWrite;
	logic statusWrite;
	logic cntWrite;
	logic addrOk;
	assign apbDone = psel & penable & pready_ff;
	assign addrOk = (paddr == REG_CTRL) | (paddr == REG_STATUS) | (paddr == REG_CRC_CNT);
	assign ctrlWrite = apbDone & pwrite & (paddr == REG_CTRL);
	assign statusWrite = apbDone & pwrite & (paddr == REG_STATUS);
	assign cntWrite = apbDone & pwrite & (paddr == REG_CRC_CNT);

	tef_loss_type lossSel;
	logic [1:0] syncMode;
	logic japanSel;
	logic alarmMethod;
	logic txAlarm;
	logic checkEn;
	assign lossSel = tef_loss_type'(ctrl_ff[CTRL_LOSS_SEL +: 2]);
	assign syncMode = {ctrl_ff[CTRL_MULTI_CAND], ctrl_ff[CTRL_SEP_SYNC]};
	assign japanSel = ctrl_ff[CTRL_JAPAN];
	assign alarmMethod = ctrl_ff[CTRL_ALARM_METHOD];
	assign txAlarm = ctrl_ff[CTRL_TX_ALARM];
	assign checkEn = ctrl_ff[CTRL_CHECK_EN];

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_ff <= CTRL_RESET;
			forcePulse_ff <= 1'b0;
			extLossPulse_ff <= 1'b0;
		end else begin
			forcePulse_ff <= ctrlWrite & pwdata[CTRL_FORCE_RESYNC];
			extLossPulse_ff <= ctrlWrite & pwdata[CTRL_EXT_LOSS];
			if (ctrlWrite) begin
				// Trigger bits never store
				ctrl_ff <= {pwdata[11:2], 2'b00};
			end
		end
	end

	// One wait state: the answer comes in the second access cycle
	logic [31:0] statusWord;
	logic [15:0] crcCnt_ff;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & ~addrOk;
			if (psel & penable & ~pready_ff & ~pwrite) begin
				unique case (paddr)
					REG_CTRL: prdata_ff <= {20'h0_0000, ctrl_ff};
					REG_STATUS: prdata_ff <= statusWord;
					REG_CRC_CNT: prdata_ff <= {16'h0000, crcCnt_ff};
					default: prdata_ff <= 32'h0000_0000;
				endcase
			end else begin
				prdata_ff <= 32'h0000_0000;
			end
		end
	end

	// ****************************************************************
	// Receive position counters
	// ****************************************************************
	logic [7:0] rxPos_ff;
	logic [4:0] rxFrame_ff;
	logic rxIsF;
	logic fasSlot;
	logic crcSlot;
	logic dlSlot;
	logic fasOk;
	logic mfEnd;
	logic slipReq;
	tef_sync_type syncState_ff;
	assign rxIsF = rxFire & (rxPos_ff == 8'h00);
	assign fasSlot = rxIsF & (rxFrame_ff[1:0] == FAS_PHASE); // [R1]
	assign crcSlot = rxIsF & (rxFrame_ff[1:0] == CRC_PHASE); // [R3]
	assign dlSlot = rxIsF & ~rxFrame_ff[0]; // [R2]
	assign fasOk = rxBit == FAS_PATTERN[rxFrame_ff[4:2]];
	assign mfEnd = rxFire & (rxPos_ff == FRAME_LAST) & (rxFrame_ff == MF_LAST);

	// A slip holds the counters for one bit to try the next alignment
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rxPos_ff <= 8'h00;
			rxFrame_ff <= 5'h00;
		end else if (rxFire & ~slipReq) begin
			if (rxPos_ff == FRAME_LAST) begin
				rxPos_ff <= 8'h00;
				rxFrame_ff <= (rxFrame_ff == MF_LAST) ? 5'h00 : rxFrame_ff + 5'h01; // [R1]
			end else begin
				rxPos_ff <= rxPos_ff + 8'h01;
			end
		end
	end

	// ****************************************************************
	// Receive CRC6
	// ****************************************************************
	logic [5:0] rxCrc_ff;
	logic [5:0] rxCrcPrev_ff;
	logic [5:0] rxCheck_ff;
	logic [1:0] rxCrcMf_ff;
	logic rxCrcIn;
	logic [5:0] rxCrcNext;
	logic crcMismatch;
	logic crcErrEvent;
	assign rxCrcIn = (rxIsF & ~japanSel) ? 1'b1 : rxBit; // [R19]
	assign rxCrcNext = {rxCrc_ff[4:0], 1'b0} ^ ((rxCrcIn ^ rxCrc_ff[5]) ? CRC_POLY : 6'h00); // [R22]
	// Check bits arriving this multiframe cover the previous one
	assign crcMismatch = mfEnd & checkEn & rxCrcMf_ff[1] & (rxCheck_ff != rxCrcPrev_ff); // [R15]
	assign crcErrEvent = crcMismatch & (syncState_ff == SY_LOCK);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rxCrc_ff <= 6'h00;
			rxCrcPrev_ff <= 6'h00;
			rxCheck_ff <= 6'h00;
			rxCrcMf_ff <= 2'b00;
		end else if (rxFire & slipReq) begin
			rxCrc_ff <= 6'h00;
			rxCrcMf_ff <= 2'b00;
		end else if (rxFire) begin
			if (crcSlot) begin
				rxCheck_ff[3'h5 - rxFrame_ff[4:2]] <= rxBit; // [R3]
			end
			if (mfEnd) begin
				rxCrc_ff <= 6'h00;
				rxCrcPrev_ff <= rxCrcNext; // [R22]
				rxCrcMf_ff <= {rxCrcMf_ff[0], 1'b1};
			end else begin
				rxCrc_ff <= rxCrcNext;
			end
		end
	end

	// ****************************************************************
	// Synchronizer
	// ****************************************************************
	logic [4:0] huntOk_ff;
	logic [12:0] slipCnt_ff;
	logic candMem_ff;
	logic restartFlag_ff;
	logic [4:0] fasHist_ff;
	logic [2:0] mfErr_ff;
	logic [2:0] badMf_ff;
	logic [4:0] huntNeed;
	logic [4:0] histNext;
	logic [2:0] mfErrNext;
	logic lossNow;
	logic cfmFail;
	logic slipWrap;
	assign huntNeed = (syncMode == MODE_THREE) ? HUNT_NEED_THREE : HUNT_NEED_ONE; // [R8]
	assign histNext = {fasHist_ff[3:0], ~fasOk};
	assign mfErrNext = mfErr_ff + {2'b00, fasSlot & ~fasOk};
	assign cfmFail = (syncState_ff == SY_CONFIRM) & crcMismatch; // [R11]
	assign slipReq = ((syncState_ff != SY_LOCK) & fasSlot & ~fasOk) | cfmFail;
	assign slipWrap = rxFire & slipReq & (slipCnt_ff == SLIP_LAST);

	function automatic logic [2:0] tef_ones(input logic [4:0] v);
		tef_ones = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]} + {2'b00, v[4]};
	endfunction

	always_comb begin
		lossNow = 1'b0;
		unique case (lossSel) // [R5]
			LOSS_2OF4: lossNow = fasSlot & (tef_ones({1'b0, histNext[3:0]}) >= LOSS_ERR_MIN);
			LOSS_2OF5: lossNow = fasSlot & (tef_ones(histNext) >= LOSS_ERR_MIN);
			LOSS_MF: lossNow = fasSlot & (mfErrNext >= LOSS_ERR_MIN);
			LOSS_4MF: lossNow = mfEnd & (mfErrNext != 3'h0) & (badMf_ff == LOSS_BAD_MF - 3'h1);
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			syncState_ff <= SY_HUNT;
			huntOk_ff <= 5'h00;
			slipCnt_ff <= 13'h0000;
			candMem_ff <= 1'b0;
			restartFlag_ff <= 1'b0;
			fasHist_ff <= 5'h00;
			mfErr_ff <= 3'h0;
			badMf_ff <= 3'h0;
		end else begin
			unique case (syncState_ff)
				SY_HUNT: begin
					if (extLossPulse_ff | (forcePulse_ff & ~candMem_ff)) begin
						huntOk_ff <= 5'h00;
						slipCnt_ff <= 13'h0000;
					end else if (forcePulse_ff) begin
						syncState_ff <= SY_LOCK; // [R4] [R7]
						candMem_ff <= 1'b0;
					end else if (fasSlot & fasOk) begin
						huntOk_ff <= huntOk_ff + 5'h01;
						if (huntOk_ff + 5'h01 >= HUNT_NEED_ONE) begin
							candMem_ff <= 1'b1;
						end
						if (huntOk_ff + 5'h01 == huntNeed) begin
							// Three-pattern mode stays here until 18 good bits
							syncState_ff <= (syncMode == MODE_CRC) ? SY_CONFIRM : SY_LOCK; // [R4] [R8]
							candMem_ff <= syncMode == MODE_CRC;
							slipCnt_ff <= 13'h0000;
						end
					end else if (rxFire & slipReq) begin
						huntOk_ff <= 5'h00;
						candMem_ff <= 1'b0;
						slipCnt_ff <= slipWrap ? 13'h0000 : slipCnt_ff + 13'h0001;
						if (slipWrap) begin
							restartFlag_ff <= ~restartFlag_ff; // [R10] [R21]
						end
					end
				end
				SY_CONFIRM: begin
					if (extLossPulse_ff) begin
						syncState_ff <= SY_HUNT;
						huntOk_ff <= 5'h00;
						candMem_ff <= 1'b0;
					end else if (forcePulse_ff) begin
						syncState_ff <= SY_LOCK; // [R7]
						candMem_ff <= 1'b0;
					end else if (rxFire & slipReq) begin
						syncState_ff <= SY_HUNT; // [R11]
						huntOk_ff <= 5'h00;
						candMem_ff <= 1'b0;
					end else if (mfEnd & (rxCrcMf_ff[1] | ~checkEn)) begin
						syncState_ff <= SY_LOCK; // [R11]
						candMem_ff <= 1'b0;
					end
				end
				SY_LOCK: begin
					if (forcePulse_ff & (syncMode == MODE_STEP)) begin
						// Only the current alignment is dropped; hunting resumes from it
						syncState_ff <= SY_HUNT; // [R9]
						huntOk_ff <= 5'h00;
					end else if (forcePulse_ff | extLossPulse_ff | lossNow) begin
						syncState_ff <= SY_HUNT; // [R5] [R6]
						huntOk_ff <= 5'h00;
						slipCnt_ff <= 13'h0000;
					end
				end
				default: syncState_ff <= SY_HUNT;
			endcase
			if (syncState_ff != SY_LOCK) begin
				fasHist_ff <= 5'h00;
				mfErr_ff <= 3'h0;
				badMf_ff <= 3'h0;
			end else if (rxFire) begin
				if (fasSlot) begin
					fasHist_ff <= histNext;
				end
				if (mfEnd) begin
					mfErr_ff <= 3'h0;
					badMf_ff <= (mfErrNext != 3'h0) ? badMf_ff + 3'h1 : 3'h0;
				end else begin
					mfErr_ff <= mfErrNext;
				end
			end
		end
	end

	// ****************************************************************
	// Remote alarm detection
	// ****************************************************************
	logic [7:0] dlHist_ff;
	logic [7:0] alarmWin_ff;
	logic [7:0] alarmErr_ff;
	logic alarm_ff;
	logic dlErr;
	// Pattern repeats every 16 bits, so each bit inverts the one eight earlier
	assign dlErr = japanSel ? ~rxBit : (rxBit == dlHist_ff[7]); // [R12] [R13]

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dlHist_ff <= 8'h00;
			alarmWin_ff <= 8'h00;
			alarmErr_ff <= 8'h00;
			alarm_ff <= 1'b0;
		end else if (syncState_ff != SY_LOCK) begin
			alarmWin_ff <= 8'h00;
			alarmErr_ff <= 8'h00;
			alarm_ff <= 1'b0;
		end else if (dlSlot) begin
			dlHist_ff <= {dlHist_ff[6:0], rxBit};
			if (alarmWin_ff == ALARM_WINDOW_LAST) begin
				// Nine bits, so a window full of errors cannot wrap to zero
				alarm_ff <= ({1'b0, alarmErr_ff} + {8'h00, dlErr}) <= {1'b0, ALARM_ERR_MAX}; // [R12]
				alarmWin_ff <= 8'h00;
				alarmErr_ff <= 8'h00;
			end else begin
				alarmWin_ff <= alarmWin_ff + 8'h01;
				alarmErr_ff <= alarmErr_ff + {7'h00, dlErr};
			end
		end
	end

	// ****************************************************************
	// CRC error counting and status
	// ****************************************************************
	logic crcErrSticky_ff;
	logic rxCrcBad_ff;
	logic inSync_ff;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			crcCnt_ff <= 16'h0000;
			crcErrSticky_ff <= 1'b0;
			rxCrcBad_ff <= 1'b0;
			inSync_ff <= 1'b0;
		end else begin
			inSync_ff <= syncState_ff == SY_LOCK;
			if (crcErrEvent) begin
				crcCnt_ff <= cntWrite ? 16'h0001 : crcCnt_ff + 16'h0001; // [R16] [R19]
			end else if (cntWrite) begin
				crcCnt_ff <= 16'h0000;
			end
			// Set wins over the write-one-to-clear
			crcErrSticky_ff <= crcErrEvent | (crcErrSticky_ff & ~(statusWrite & pwdata[STAT_CRC_ERR])); // [R16]
			if (mfEnd) begin
				rxCrcBad_ff <= crcMismatch;
			end
		end
	end
	assign statusWord = {27'h000_0000, crcErrSticky_ff, alarm_ff, restartFlag_ff, ~inSync_ff,
		inSync_ff}; // [R20]

	// ****************************************************************
	// Transmit framing
	// ****************************************************************
	logic [7:0] txPos_ff;
	logic [4:0] txFrame_ff;
	logic [5:0] txCrc_ff;
	logic [5:0] txCrcPrev_ff;
	logic [3:0] txDlCnt_ff;
	logic txInv_ff;
	logic txLine_ff;
	logic txStb_ff;
	logic txIsF;
	logic txOut;
	logic txCrcIn;
	logic [5:0] txCrcNext;
	logic txMfStart;
	assign txIsF = txPos_ff == 8'h00;
	assign txMfStart = txFire & txIsF & (txFrame_ff == 5'h00);

	always_comb begin
		txOut = pinSync_ff[2];
		if (txIsF) begin
			if (txFrame_ff[1:0] == FAS_PHASE) begin
				txOut = FAS_PATTERN[txFrame_ff[4:2]]; // [R1]
			end else if (txFrame_ff[1:0] == CRC_PHASE) begin
				txOut = checkEn ? txCrcPrev_ff[3'h5 - txFrame_ff[4:2]] ^ txInv_ff : 1'b1; // [R15] [R3]
			end else begin
				txOut = ~(txAlarm & ~alarmMethod & ~japanSel & (txDlCnt_ff >= DL_HALF)); // [R2] [R13]
			end
		end else if (txAlarm & alarmMethod & ((txPos_ff[2:0] - 3'h1) == TS_BIT2)) begin
			txOut = 1'b1; // [R14]
		end
	end

	assign txCrcIn = (txIsF & ~japanSel) ? 1'b1 : txOut; // [R19]
	assign txCrcNext = {txCrc_ff[4:0], 1'b0} ^ ((txCrcIn ^ txCrc_ff[5]) ? CRC_POLY : 6'h00); // [R22]

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			txPos_ff <= 8'h00;
			txFrame_ff <= 5'h00;
			txCrc_ff <= 6'h00;
			txCrcPrev_ff <= 6'h00;
			txDlCnt_ff <= 4'h0;
			txInv_ff <= 1'b0;
			txLine_ff <= 1'b1;
			txStb_ff <= 1'b0;
		end else begin
			txStb_ff <= txFire;
			if (txFire) begin
				txLine_ff <= txOut;
				if (txMfStart) begin
					txInv_ff <= ctrl_ff[CTRL_TX_INV] | (ctrl_ff[CTRL_AUTO_INV] & rxCrcBad_ff); // [R17] [R18]
				end
				if (txIsF & ~txFrame_ff[0]) begin
					txDlCnt_ff <= txDlCnt_ff + 4'h1;
				end
				if (txPos_ff == FRAME_LAST) begin
					txPos_ff <= 8'h00;
					txFrame_ff <= (txFrame_ff == MF_LAST) ? 5'h00 : txFrame_ff + 5'h01;
				end else begin
					txPos_ff <= txPos_ff + 8'h01;
				end
				if ((txPos_ff == FRAME_LAST) & (txFrame_ff == MF_LAST)) begin
					txCrcPrev_ff <= txCrcNext; // [R22]
					txCrc_ff <= 6'h00;
				end else begin
					txCrc_ff <= txCrcNext;
				end
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign txLineBit = txLine_ff;
	assign txLineStrobe = txStb_ff;
	assign inSync = inSync_ff;
	assign remoteAlarm = alarm_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	crc_count_a: assert property (crcErrEvent && !cntWrite // [R16]
		|=> crcCnt_ff == $past(crcCnt_ff) + 16'h0001)
		else $error("CRC error not counted");
	count_hold_a: assert property (syncState_ff != SY_LOCK && !cntWrite // [R16]
		|=> $stable(crcCnt_ff))
		else $error("CRC counter moved out of sync");
	tx_ones_a: assert property (txFire && txIsF && !checkEn // [R15]
		&& txFrame_ff[1:0] == CRC_PHASE |=> txLineBit)
		else $error("Check bit not one while disabled");
	// Frame number holds across the F bit, so no past value is needed
	tx_fas_a: assert property (txFire && txIsF && txFrame_ff[1:0] == FAS_PHASE // [R1]
		|=> txLineBit == FAS_PATTERN[txFrame_ff[4:2]])
		else $error("Wrong alignment bit sent");
	loss_flag_a: assert property (1'b1 |=> // [R20]
		statusWord[STAT_FRAME_LOSS] == ($past(syncState_ff) != SY_LOCK))
		else $error("Frame loss flag wrong");
	force_single_a: assert property (syncState_ff == SY_LOCK && syncMode == MODE_SINGLE // [R6]
		&& (forcePulse_ff || extLossPulse_ff) |=> syncState_ff == SY_HUNT)
		else $error("Force did not restart search");
	restart_toggle_a: assert property (syncState_ff == SY_HUNT && slipWrap // [R21]
		&& !forcePulse_ff && !extLossPulse_ff |=> restartFlag_ff != $past(restartFlag_ff))
		else $error("Restart flag did not toggle");
	bit2_alarm_a: assert property (txFire && !txIsF && txAlarm && alarmMethod // [R14]
		&& (txPos_ff[2:0] - 3'h1) == TS_BIT2 |=> txLineBit)
		else $error("Bit 2 not set for alarm");
	invert_or_a: assert property (txMfStart && ctrl_ff[CTRL_TX_INV] |=> txInv_ff) // [R18]
		else $error("Manual inversion lost");

endmodule

/* File: logic/tef_pkg.sv */
// Constants, register map and types of the T1 extended superframe framer
package tef_pkg;

	// ****************************************************************
	// Frame geometry
	// ****************************************************************
	localparam logic [7:0] FRAME_LAST = 8'hC0;
	localparam logic [4:0] MF_LAST = 5'h17;
	localparam logic [12:0] SLIP_LAST = 13'h1217;
	localparam logic [5:0] FAS_PATTERN = 6'h34;
	localparam logic [1:0] FAS_PHASE = 2'h3;
	localparam logic [1:0] CRC_PHASE = 2'h1;
	localparam logic [2:0] TS_BIT2 = 3'h1;

	// ****************************************************************
	// Synchronizer and check figures
	// ****************************************************************
	localparam logic [5:0] CRC_POLY = 6'h03;
	localparam logic [4:0] HUNT_NEED_ONE = 5'h06;
	localparam logic [4:0] HUNT_NEED_THREE = 5'h12;
	localparam logic [2:0] LOSS_ERR_MIN = 3'h2;
	localparam logic [2:0] LOSS_BAD_MF = 3'h4;
	localparam logic [7:0] ALARM_WINDOW_LAST = 8'hFF;
	localparam logic [7:0] ALARM_ERR_MAX = 8'h01;
	localparam logic [3:0] DL_HALF = 4'h8;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_CRC_CNT = 12'h008;
	localparam int CTRL_FORCE_RESYNC = 0;
	localparam int CTRL_EXT_LOSS = 1;
	localparam int CTRL_LOSS_SEL = 2;
	localparam int CTRL_MULTI_CAND = 4;
	localparam int CTRL_SEP_SYNC = 5;
	localparam int CTRL_JAPAN = 6;
	localparam int CTRL_ALARM_METHOD = 7;
	localparam int CTRL_TX_ALARM = 8;
	localparam int CTRL_CHECK_EN = 9;
	localparam int CTRL_AUTO_INV = 10;
	localparam int CTRL_TX_INV = 11;
	localparam int STAT_SYNC = 0;
	localparam int STAT_FRAME_LOSS = 1;
	localparam int STAT_RESTART = 2;
	localparam int STAT_REMOTE_ALARM = 3;
	localparam int STAT_CRC_ERR = 4;
	localparam logic [11:0] CTRL_RESET = 12'h000;

	// ****************************************************************
	// Types
	// ****************************************************************
	localparam logic [1:0] MODE_SINGLE = 2'b00;
	localparam logic [1:0] MODE_THREE = 2'b01;
	localparam logic [1:0] MODE_STEP = 2'b10;
	localparam logic [1:0] MODE_CRC = 2'b11;

	typedef enum logic [1:0] {
		LOSS_2OF4 = 2'b00,
		LOSS_2OF5 = 2'b01,
		LOSS_MF = 2'b10,
		LOSS_4MF = 2'b11
	} tef_loss_type;

	typedef enum logic [1:0] {
		SY_HUNT = 2'b00,
		SY_CONFIRM = 2'b01,
		SY_LOCK = 2'b10
	} tef_sync_type;

endpackage

/* File: verif/tef_framer_tb.sv */
// Self-checking bench of the extended superframe framer
module tef_framer_tb
	import tef_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic rxLineBit, rxLineStrobe, txPayloadBit, txLineBit, txLineStrobe;
	logic inSync, remoteAlarm, badFas, badCrc;
	logic [5:0] txCrc, txCrcLast;
	int nErrors, cmpCount, cycles, txIdx, p, m, f;

	tef_framer u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxLineBit(rxLineBit), .rxLineStrobe(rxLineStrobe),
		.txPayloadBit(txPayloadBit), .txPayloadStrobe(rxLineStrobe), .txLineBit(txLineBit),
		.txLineStrobe(txLineStrobe), .inSync(inSync), .remoteAlarm(remoteAlarm));
	tef_line_model u_line (.clk_sys(clk_sys), .reset_n(reset_n), .badFas(badFas),
		.badCrc(badCrc), .rxLineBit(rxLineBit), .rxLineStrobe(rxLineStrobe),
		.txPayloadBit(txPayloadBit));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nErrors++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		// Idle edge first: a release and the next setup never share a time step
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Wait a few bits into multiframe n so settings hold for all of it
	task automatic at_mf(input int n);
		wait (txIdx >= n * 4632 + 5);
		@(posedge clk_sys);
	endtask

	task automatic end_of_test();
		$display("counts: %0d compares, %0d mismatches", cmpCount, nErrors);
		if (nErrors == 0 && cmpCount > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ****************************************************************
	// Transmit model: F bits per frame, running check sum
	// ****************************************************************
	always @(posedge clk_sys) begin
		if (txLineStrobe === 1'b1) begin
			p = txIdx % 4632;
			m = txIdx / 4632;
			f = p / 193 + 1;
			if (p % 193 == 0 && m < 4 && f % 4 == 0)
				chk(txLineBit, FAS_PATTERN[f / 4 - 1]);
			// Multiframe 1 is skipped: its sum spans the enable change
			if (p % 193 == 0 && m < 4 && m != 1 && f % 4 == 2)
				chk(txLineBit, (m == 0) ? 1'b1
					: txCrcLast[5 - (f - 2) / 4] ^ (m == 3));
			txCrc = {txCrc[4:0], 1'b0} ^ ((((p % 193 == 0) | txLineBit) ^ txCrc[5]) ? 6'h03 : 6'h00);
			if (p == 4631) begin
				txCrcLast = txCrc;
				txCrc = 6'h00;
			end
			txIdx = txIdx + 1;
		end
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 95000) begin
			nErrors++;
			end_of_test();
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{reset_n, psel, penable, pwrite, badFas, badCrc} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		txCrc = 6'h00;
		txCrcLast = 6'h00;
		void'($urandom(32'h3D7E));
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd, 32'h0000_0002);
		apb(1'b0, REG_CRC_CNT, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("test registers done");
		at_mf(1);
		chk(inSync, 1'b1);
		apb(1'b1, REG_CTRL, 32'h0000_0200);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h0000_0200);
		$display("test lock done");
		at_mf(2);
		badCrc <= 1'b1;
		apb(1'b1, REG_CRC_CNT, 32'h0);
		// Inversion is latched at a multiframe start, so it shows from the next one
		apb(1'b1, REG_CTRL, 32'h0000_0A00);
		at_mf(3);
		badCrc <= 1'b0;
		badFas <= 1'b1;
		wait (txIdx >= 3 * 4632 + 300);
		apb(1'b0, REG_CRC_CNT, 32'h0);
		chk(rd, 32'h0000_0001);
		chk(remoteAlarm, 1'b0);
		$display("test check errors done");
		at_mf(4);
		badFas <= 1'b0;
		chk(inSync, 1'b0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd & 32'h0000_0013, 32'h0000_0012);
		$display("test loss done");
		end_of_test();
	end
endmodule

/* File: verif/tef_line_model.sv */
// Line interface model: framed receive stream, shared bit strobe
module tef_line_model
	import tef_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic badFas,
	input wire logic badCrc,
	output logic rxLineBit,
	output logic rxLineStrobe,
	output logic txPayloadBit
);
	timeunit 1ns;
	timeprecision 1ns;
	int pos;
	int phase;
	logic bitNow;
	logic [5:0] cNext;
	logic [5:0] crcRun;
	logic [5:0] crcLast;

	// ****************************************************************
	// Bit source
	// ****************************************************************
	function automatic logic lineBit(input int p);
		int f;
		f = p / 193 + 1;
		if (p % 193 != 0)
			return 1'($urandom);
		if (f % 4 == 0)
			return FAS_PATTERN[f / 4 - 1] ^ badFas;
		if (f % 2 == 1)
			return 1'b1;
		return crcLast[5 - (f - 2) / 4] ^ (badCrc && f == 2);
	endfunction

	// ****************************************************************
	// Strobe high two cycles, low two; data settles before the rise
	// ****************************************************************
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pos <= 0;
			phase <= -8;
			crcRun <= 6'h00;
			crcLast <= 6'h00;
			rxLineBit <= 1'b0;
			rxLineStrobe <= 1'b0;
			txPayloadBit <= 1'b0;
		end else begin
			phase <= (phase == 3) ? 0 : phase + 1;
			rxLineStrobe <= (phase == 1 || phase == 2);
			if (phase == 0) begin
				bitNow = lineBit(pos);
				rxLineBit <= bitNow;
				txPayloadBit <= 1'($urandom);
				// F bits count as ones in the check sum
				cNext = {crcRun[4:0], 1'b0} ^ ((((pos % 193 == 0) | bitNow) ^ crcRun[5]) ? 6'h03 : 6'h00);
				crcRun <= (pos == 4631) ? 6'h00 : cNext;
				if (pos == 4631)
					crcLast <= cNext;
				pos <= (pos == 4631) ? 0 : pos + 1;
			end
		end
	end
endmodule
